// >>> core/lcdc_pkg.sv
/*
 * lcdc_pkg: register indices, field positions, reset values, codes and
 * division ratios of the segment LCD duty/clock controller.
 * assumes: 32-bit classic Wishbone, register index = byte address / 4.
 */
package lcdc_pkg;

    // ------------------------------------------------------------
    // register map (word indices)
    // ------------------------------------------------------------
    localparam logic [6:0] IDX_DISPLAY_CONTROL   = 7'h13;
    localparam logic [6:0] IDX_DUTY_CLOCK_SELECT = 7'h14;
    localparam logic [6:0] IDX_STATUS            = 7'h15;
    localparam logic [6:0] IDX_RAM_FIRST         = 7'h50;
    localparam logic [6:0] IDX_RAM_LAST          = 7'h6f;
    localparam int         RAM_WORDS             = 32;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         CTRL_DISPLAY_BIT  = 0;
    localparam int         CTRL_POWER_BIT    = 1;
    localparam int         CTRL_LOWPOWER_BIT = 2;
    localparam int         MODE_DUTY_LSB     = 0;
    localparam int         MODE_CLKSEL_LSB   = 2;
    localparam logic [2:0] CTRL_RESET        = 3'h0;
    localparam logic [3:0] MODE_RESET        = 4'h0;

    // ------------------------------------------------------------
    // duty and clock-select codes
    // ------------------------------------------------------------
    localparam logic [1:0] DUTY_QUARTER = 2'h0;
    localparam logic [1:0] DUTY_THIRD   = 2'h1;
    localparam logic [1:0] DUTY_HALF    = 2'h2;
    localparam logic [1:0] DUTY_STATIC  = 2'h3;
    localparam logic [1:0] CLK_SUB64    = 2'h0;
    localparam logic [1:0] CLK_SYS256   = 2'h1;
    localparam logic [1:0] CLK_SYS2048  = 2'h2;
    localparam logic [1:0] CLK_TIMER    = 2'h3;

    // ------------------------------------------------------------
    // division ratios
    // ------------------------------------------------------------
    localparam logic [12:0] DIV_SUB64   = 13'h0040;
    localparam logic [12:0] DIV_SYS256  = 13'h0100;
    localparam logic [12:0] DIV_SYS2048 = 13'h0800;
    localparam logic [12:0] DIV_SUB512  = 13'h0200;
    localparam logic [12:0] DIV_SYS4096 = 13'h1000;

    typedef struct packed {
        logic lp_display;
        logic power_on;
        logic display_on;
    } lcdc_ctrl_t;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic [1:0] duty;
    } lcdc_mode_t;

    // number of active commons for a duty code
    function automatic logic [2:0] lcdc_ncom(input logic [1:0] duty);
        case (duty)
            DUTY_QUARTER: lcdc_ncom = 3'h4;
            DUTY_THIRD:   lcdc_ncom = 3'h3;
            DUTY_HALF:    lcdc_ncom = 3'h2;
            default:      lcdc_ncom = 3'h1;
        endcase
    endfunction : lcdc_ncom

endpackage : lcdc_pkg

// >>> core/lcdc_prescaler.sv
/*
 * lcdc_prescaler: divides a source tick stream by a run-time ratio.
 * assumes: tick_in is a one-cycle pulse synchronous to mclk.
 */
`timescale 1ns/100ps
`default_nettype none
module lcdc_prescaler
    import lcdc_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // control
    input  wire logic        restart,
    input  wire logic        tick_in,
    input  wire logic [12:0] divisor,
    // output
    output var  logic        tick_out
);
    logic [12:0] count_q;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n || restart) begin
            count_q  <= 13'h0000;
            tick_out <= 1'b0;
        end else if (tick_in) begin
            if (count_q == 13'(divisor - 13'h0001)) begin
                count_q  <= 13'h0000;
                tick_out <= 1'b1;
            end else begin
                count_q  <= 13'(count_q + 13'h0001);
                tick_out <= 1'b0;
            end
        end else begin
            tick_out <= 1'b0;
        end
    end

endmodule : lcdc_prescaler
`default_nettype wire

// >>> core/lcdc_core.sv
/*
 * lcdc_core: display control, duty/clock select, common scan and segment
 * drive of a segment LCD controller, with its display RAM, over Wishbone.
 * assumes: subclock and system-divider ticks are mclk-synchronous pulses;
 * low_power_mode is high in watch or subactive mode.
 */
// The register addresses and the Wishbone slave port were left to the implementer.
// What this block does
// - control register bits: 0 display/blank, 1 divider power, 2 low-power display
// - power bit low switches the dividing-resistor supply off
// - duty code 00 quarter, 01 third, 10 half, 11 static
// - clock code 01 system divider /256, 10 system divider /2048
// - clock code 00 gives subclock /64
// - clock code 11 with timer bit low gives system divider /4096
// - clock code 11 with timer bit high gives subclock /512
// - frame rate is LCD clock divided by the number of commons
// - control register is three bits, write-only, at index 0x13
// - duty/clock register is write-only at index 0x14
// - low-power mode without display bit drives pins low, power off
`timescale 1ns/100ps
`default_nettype none
module lcdc_core
    import lcdc_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [8:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    // clock sources and mode
    input  wire logic        subclk_tick,
    input  wire logic        sysdiv_tick,
    input  wire logic        timer_a_watch_select_bit,
    input  wire logic        low_power_mode,
    // panel
    output var  logic [3:0]  com_o,
    output var  logic [31:0] seg_o,
    output var  logic        divider_power_on_o
);
    lcdc_ctrl_t  ctrl_q;
    lcdc_mode_t  mode_q;
    logic [3:0]  ram_q [RAM_WORDS];
    logic [1:0]  com_idx_q;
    logic        timer_sel_q;
    logic        bus_hit;
    logic [6:0]  idx;
    logic        ctrl_wr;
    logic        mode_wr;
    logic        ram_sel;
    logic        lp_off;
    logic        src_tick;
    logic [12:0] divisor;
    logic        restart;
    logic        lcd_tick;
    logic [2:0]  ncom;

    function automatic logic [4:0] ram_slot(input logic [6:0] a);
        ram_slot = 5'(a - IDX_RAM_FIRST);
    endfunction : ram_slot

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign idx     = wb_adr_i[8:2];
    assign ctrl_wr = bus_hit && wb_we_i && wb_sel_i[0] && idx == IDX_DISPLAY_CONTROL;
    assign mode_wr = bus_hit && wb_we_i && wb_sel_i[0] && idx == IDX_DUTY_CLOCK_SELECT;
    assign ram_sel = idx >= IDX_RAM_FIRST && idx <= IDX_RAM_LAST;
    assign lp_off  = low_power_mode && !ctrl_q.lp_display;
    assign ncom    = lcdc_ncom(mode_q.duty);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_hit;
        end
    end

    // write-only registers read back as zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_hit && !wb_we_i) begin
            if (idx == IDX_STATUS) begin
                wb_dat_o <= {27'h000_0000, lp_off, divider_power_on_o, ctrl_q.display_on, com_idx_q};
            end else if (ram_sel) begin
                wb_dat_o <= {28'h000_0000, ram_q[ram_slot(idx)]};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_q <= lcdc_ctrl_t'(CTRL_RESET);
        end else if (ctrl_wr) begin
            ctrl_q <= lcdc_ctrl_t'(wb_dat_i[CTRL_LOWPOWER_BIT:CTRL_DISPLAY_BIT]);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode_q <= lcdc_mode_t'(MODE_RESET);
        end else if (mode_wr) begin
            mode_q <= lcdc_mode_t'(wb_dat_i[MODE_CLKSEL_LSB+1:MODE_DUTY_LSB]);
        end
    end

    // display RAM is dual ported: bus writes, scanner reads every cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < RAM_WORDS; i++) begin
                ram_q[i] <= 4'h0;
            end
        end else if (bus_hit && wb_we_i && wb_sel_i[0] && ram_sel) begin
            ram_q[ram_slot(idx)] <= wb_dat_i[3:0];
        end
    end

    // ------------------------------------------------------------
    // LCD clock selection
    // ------------------------------------------------------------
    always_comb begin
        case (mode_q.clk_sel)
            CLK_SUB64: begin
                src_tick = subclk_tick;
                divisor  = DIV_SUB64;
            end
            CLK_SYS256: begin
                src_tick = sysdiv_tick;
                divisor  = DIV_SYS256;
            end
            CLK_SYS2048: begin
                src_tick = sysdiv_tick;
                divisor  = DIV_SYS2048;
            end
            default: begin
                src_tick = timer_sel_q ? subclk_tick : sysdiv_tick;
                divisor  = timer_sel_q ? DIV_SUB512 : DIV_SYS4096;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            timer_sel_q <= 1'b0;
        end else begin
            timer_sel_q <= timer_a_watch_select_bit;
        end
    end

    // a new ratio restarts the count so no stretched first period appears
    assign restart = mode_wr || (timer_sel_q != timer_a_watch_select_bit);

    lcdc_prescaler u_prescaler (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .restart  (restart),
        .tick_in  (src_tick),
        .divisor  (divisor),
        .tick_out (lcd_tick)
    );

    // ------------------------------------------------------------
    // common scan and drive
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n || mode_wr) begin
            com_idx_q <= 2'h0;
        end else if (lcd_tick) begin
            com_idx_q <= ({1'b0, com_idx_q} >= 3'(ncom - 3'h1)) ? 2'h0 : 2'(com_idx_q + 2'h1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            com_o <= 4'h0;
            seg_o <= 32'h0000_0000;
        end else if (lp_off) begin
            com_o <= 4'h0;
            seg_o <= 32'h0000_0000;
        end else begin
            com_o <= 4'(4'h1 << com_idx_q);
            for (int i = 0; i < RAM_WORDS; i++) begin
                seg_o[i] <= ctrl_q.display_on && ram_q[i][com_idx_q];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            divider_power_on_o <= 1'b0;
        end else begin
            divider_power_on_o <= ctrl_q.power_on && !lp_off;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [12:0] gap_q;
    logic        clean_q;

    // source ticks seen since the last LCD tick, valid only without restart
    // a source tick in the LCD tick cycle already counts toward the next period
    always_ff @(posedge mclk) begin
        if (!rst_n || restart) begin
            gap_q   <= 13'h0000;
            clean_q <= 1'b0;
        end else if (lcd_tick) begin
            gap_q   <= {12'h000, src_tick};
            clean_q <= 1'b1;
        end else if (src_tick) begin
            gap_q <= 13'(gap_q + 13'h0001);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_ACK_PULSE: assert property (bus_hit |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");
    AST_CTRL_WRITE: assert property (ctrl_wr |=> ctrl_q == $past(wb_dat_i[2:0]))
        else $error("control register not updated");
    AST_MODE_WRITE: assert property (mode_wr |=> mode_q == $past(wb_dat_i[3:0]))
        else $error("duty/clock register not updated");
    AST_WO_READ: assert property (bus_hit && !wb_we_i && idx == IDX_DISPLAY_CONTROL |=> wb_dat_o == 32'h0)
        else $error("write-only register read nonzero");
    AST_POWER_OFF: assert property (!ctrl_q.power_on |=> !divider_power_on_o)
        else $error("divider power on with power bit clear");
    AST_LP_DARK: assert property (lp_off ##1 lp_off |=> com_o == 4'h0 && seg_o == 32'h0 && !divider_power_on_o)
        else $error("pins active in low-power mode without display bit");
    AST_BLANK: assert property (!ctrl_q.display_on && !ctrl_wr |=> seg_o == 32'h0)
        else $error("segments driven while blanked");
    AST_COM_RANGE: assert property ({1'b0, com_idx_q} < ncom)
        else $error("common index beyond duty");
    AST_WRAP: assert property (lcd_tick && !mode_wr && {1'b0, com_idx_q} == 3'(ncom - 3'h1) |=> com_idx_q == 2'h0)
        else $error("scan did not wrap after last common");
    AST_RATIO: assert property (lcd_tick && clean_q |-> gap_q == $past(divisor))
        else $error("LCD clock ratio wrong");

    COV_TIMER_SUB: cover property (lcd_tick && mode_q.clk_sel == CLK_TIMER && timer_sel_q);
    COV_LP_OFF: cover property (lp_off && ctrl_q.power_on);
    COV_STATIC_WRAP: cover property (lcd_tick && mode_q.duty == DUTY_STATIC);
    COV_QUARTER_LAST: cover property (lcd_tick && mode_q.duty == DUTY_QUARTER && com_idx_q == 2'h3);

endmodule : lcdc_core
`default_nettype wire

// >>> bench/lcdc_panel_model.sv
/*
 * lcdc_panel_model: passive segment panel as seen from the common pins.
 * assumes: pins sampled on mclk; the panel drives nothing back.
 */
`timescale 1ns/100ps
`default_nettype none
module lcdc_panel_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // common pins and bench control
    input  wire logic [3:0] com_o,
    input  wire logic       clr,
    // observations
    output var  logic [3:0] com_seen,
    output var  logic       overlap
);
    // ----------------------------------------------------------------
    // commons seen since clear; two at once would short the panel
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_n || clr) begin
            {com_seen, overlap} <= 5'h00;
        end else begin
            com_seen <= com_seen | com_o;
            overlap  <= overlap | ($countones(com_o) > 1);
        end
    end
endmodule : lcdc_panel_model
`default_nettype wire

// >>> bench/test_lcdc_core.sv
/*
 * test_lcdc_core: register, scan, clock-select and low-power tests.
 * assumes: ticks made here, system divider every 2 and subclock every 3 cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module test_lcdc_core;
    import lcdc_pkg::*;
    logic        mclk, rst_n, cyc, stb, we, tsub, tsys, tma, lpm, clr, ovl;
    logic [8:0]  adr;
    logic [3:0]  sel, com_o, seen;
    logic [31:0] dat, q, wb_dat_o, seg_o;
    logic        wb_ack_o, pwr;
    logic [3:0]  ram [32];
    int          err_total, n_checks, tc, i, n;
    int          per [5] = '{192, 512, 4096, 8192, 1536};

    lcdc_core uut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .subclk_tick(tsub), .sysdiv_tick(tsys), .timer_a_watch_select_bit(tma),
        .low_power_mode(lpm), .com_o(com_o), .seg_o(seg_o), .divider_power_on_o(pwr));
    lcdc_panel_model panel (.mclk(mclk), .rst_n(rst_n), .com_o(com_o), .clr(clr),
        .com_seen(seen), .overlap(ovl));

    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        tc   <= tc + 1;
        tsys <= (tc % 2 == 0);
        tsub <= (tc % 3 == 0);
    end

    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    // classic single cycle; no latency assumed, only the bound cuts a hang
    task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
        int k;
        k = 0;
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'h1};
        @(posedge mclk);
        while (wb_ack_o !== 1'b1 && k < 100) begin
            @(posedge mclk);
            k++;
        end
        if (k == 100) err_total++;
        q = wb_dat_o;
        {cyc, stb} <= 2'b00;
        @(posedge mclk);
    endtask : wb

    task automatic wait_step(output int c);
        logic [3:0] s;
        s = com_o;
        c = 0;
        while (com_o === s && c < 20000) begin
            @(posedge mclk);
            c++;
        end
    endtask : wait_step

    task automatic frame(output int c);
        int k;
        k = 0;
        while (com_o === 4'h1 && k < 5000) begin
            @(posedge mclk);
            k++;
        end
        while (com_o !== 4'h1 && k < 5000) begin
            @(posedge mclk);
            k++;
        end
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        c = 1;
        while (com_o === 4'h1 && c < 5000) begin
            @(posedge mclk);
            c++;
        end
        while (com_o !== 4'h1 && c < 5000) begin
            @(posedge mclk);
            c++;
        end
    endtask : frame

    function automatic logic [31:0] expseg(input logic [3:0] c);
        logic [31:0] e;
        int j;
        j = c[1] ? 1 : c[2] ? 2 : c[3] ? 3 : 0;
        for (int m = 0; m < 32; m++) e[m] = ram[m][j];
        return e;
    endfunction : expseg

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    initial begin
        {mclk, rst_n, cyc, stb, we, tsub, tsys, tma, lpm, clr} = '0;
        {adr, sel, dat, tc} = '0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        check("power_rst", pwr, 0);
        wb(0, 9'h054, 0); check("status_rst", q & 32'h1c, 0);
        wb(1, 9'h04c, 32'h3);
        wb(0, 9'h04c, 0); check("ctrl_rd", q, 0);
        wb(0, 9'h050, 0); check("mode_rd", q, 0);
        wb(0, 9'h1fc, 0); check("unmapped", q, 0);
        check("power_on", pwr, 1);
        wb(0, 9'h054, 0); check("status", q & 32'h1c, 32'h0c);
        // external drive voltage: power switch kept off
        wb(1, 9'h04c, 32'h1);
        check("power_off", pwr, 0);
        for (i = 0; i < 32; i++) begin
            ram[i] = 4'(i * 7 + 5);
            wb(1, 9'(9'h140 + 4 * i), {28'h0, ram[i]});
        end
        for (i = 0; i < 32; i++) begin
            wb(0, 9'(9'h140 + 4 * i), 0); check("ram", q, {28'h0, ram[i]});
        end
        for (i = 0; i < 4; i++) begin
            wait_step(n); check("seg", seg_o, expseg(com_o));
        end
        // all five clock selections follow: display bit cleared first
        wb(1, 9'h04c, 32'h0);
        repeat (2) @(posedge mclk);
        check("blank", seg_o, 0);
        for (i = 0; i < 5; i++) begin
            tma <= (i == 4);
            wb(1, 9'h050, {28'h0, 2'(i > 3 ? 3 : i), 2'h0});
            wait_step(n);
            wait_step(n); check("step", n, per[i]);
        end
        tma <= 1'b0;
        for (i = 0; i < 3; i++) begin
            wb(1, 9'h050, {30'h0, 2'(i)});
            frame(n); check("frame", n, (4 - i) * 192);
            check("mask", {28'h0, seen}, {28'h0, 4'hf >> i});
        end
        wb(1, 9'h050, 32'h3);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (600) @(posedge mclk);
        check("static", {28'h0, seen}, 32'h1);
        check("overlap", ovl, 0);
        wb(1, 9'h04c, 32'h3);
        lpm <= 1'b1;
        repeat (3) @(posedge mclk);
        check("lp_com", {28'h0, com_o}, 0);
        check("lp_power", pwr, 0);
        wb(0, 9'h054, 0); check("lp_status", q & 32'h1c, 32'h14);
        // watch display: subclock source, low-power display bit set
        wb(1, 9'h050, 32'h0);
        wb(1, 9'h04c, 32'h7);
        wait_step(n);
        wait_step(n); check("lp_step", n, 192);
        check("lp_power_on", pwr, 1);
        results();
    end

    initial begin
        repeat (80000) @(posedge mclk);
        err_total++;
        results();
    end
endmodule : test_lcdc_core
`default_nettype wire
